// File: reset_init_map.vh
// Constants for the reset state initializer: offsets, field positions, reset values and codes.
`ifndef RESET_INIT_MAP_VH
`define RESET_INIT_MAP_VH
`define ADDR_RESET_CAUSE 8'h8e
`define ADDR_STATUS_COPY 8'h83
`define ADDR_CAUSE_CODE 8'hf0
`define PC_RESET_VALUE 13'h0000
`define PC_IRQ_VECTOR 13'h0004
`define STATUS_POR_TOP 5'h03
`define STATUS_MASTER_CLEAR_RESET_SLEEP_TOP 5'h02
`define STATUS_TO_BIT 4
`define STATUS_PD_BIT 3
`define CAUSE_POR_VALUE 2'h0
`define CAUSE_BOR_VALUE 2'h2
`define CAUSE_BITS_MASK 8'h03
`define CODE_NONE 3'h0
`define CODE_POR 3'h1
`define CODE_BOR 3'h2
`define CODE_MASTER_CLEAR_RESET_RUN 3'h3
`define CODE_MASTER_CLEAR_RESET_SLEEP 3'h4
`define CODE_WDT_RESET 3'h5
`define CODE_WDT_WAKE 3'h6
`define CODE_IRQ_WAKE 3'h7
`endif

// File: reset_state_initializer.v
// Reset and wake-up condition logic: program counter, status and reset-cause initial values.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "reset_init_map.vh"
module reset_state_initializer #(
   parameter PC_WIDTH = 13,
   parameter ADDR_WIDTH = 8
) (
   input wire clk,                          // Core clock, 100 MHz.
   input wire sys_rst,                      // Synchronous reset, active high.
   input wire por_req,                      // Power-on reset request pin.
   input wire bor_req,                      // Brown-out reset request pin.
   input wire master_clear_reset,           // External master-clear request pin.
   input wire watchdog_timer,               // Watchdog time-out pin.
   input wire irq_wake_req,                 // Enabled interrupt wake-up request.
   input wire sleeping,                     // Core is in sleep, same domain.
   input wire [PC_WIDTH-1:0] pc_current,    // Current program counter.
   input wire [7:0] status_current,         // Current status register value.
   input wire [7:0] irq_control_reg,        // Current interrupt control register.
   input wire [7:0] peripheral_irq_flags,   // Current peripheral flag register.
   input wire [7:0] irq_control_wake,       // Interrupt control flags causing wake-up.
   input wire [7:0] peripheral_wake,        // Peripheral flags causing wake-up.
   input wire [ADDR_WIDTH-1:0] reg_addr,    // Register address.
   input wire [7:0] reg_wdata,              // Register write data.
   input wire reg_wr,                       // Register write strobe.
   input wire reg_rd,                       // Register read strobe.
   output reg [7:0] reg_rdata,              // Read data, valid the cycle after reg_rd.
   output reg [2:0] cause_code,             // Encoded cause, held until the next cause is taken.
   output reg cause_valid,                  // Pulse marking cause_code.
   output reg pc_load,                      // Pulse: load pc_value into the core.
   output reg [PC_WIDTH-1:0] pc_value,      // Program counter to load.
   output reg status_load,                  // Pulse: load status_value.
   output reg [7:0] status_value,           // Status register to load.
   output reg irq_load,                     // Pulse: load irq flag registers.
   output reg [7:0] irq_control_value,      // New interrupt control register.
   output reg [7:0] peripheral_irq_value,   // New peripheral flag register.
   output reg vector_pending,               // Vector to 0004h after the PC+1 instruction.
   output reg [PC_WIDTH-1:0] vector_value,  // Interrupt vector address.
   output reg [7:0] reset_cause_flags       // Reset-cause register.
);

   // Sequencer states: one cause is taken in idle, then two quiet cycles follow.
   localparam ST_IDLE = 3'b001;
   localparam ST_HOLD = 3'b010;
   localparam ST_WAIT = 3'b100;

   // Bit positions of the reset sources inside the synchroniser chain.
   localparam SRC_POR = 0;
   localparam SRC_BOR = 1;
   localparam SRC_MASTER_CLEAR_RESET = 2;
   localparam SRC_WDT = 3;

   reg [3:0] sync_a;
   reg [3:0] sync_b;
   reg [3:0] prev_b;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [2:0] next_code;
   reg [7:0] next_status;
   reg [7:0] next_read;
   reg take;
   reg wake_taken;
   reg irq_wake_taken;
   reg reset_taken;
   wire [3:0] rise;

   // Rising edges of the synchronised sources. The chain idles low after reset,
   // so no false edge is seen when reset is released with the pins low.
   assign rise = sync_b & ~prev_b;

   // Rank simultaneous causes: power-on, brown-out, master-clear, watchdog.
   function [2:0] rank_cause;
      input [3:0] edges;
      input in_sleep;
      input wake;
      begin
         if (edges[SRC_POR])
            rank_cause = `CODE_POR;
         else if (edges[SRC_BOR])
            rank_cause = `CODE_BOR;
         else if (edges[SRC_MASTER_CLEAR_RESET])
            rank_cause = in_sleep ? `CODE_MASTER_CLEAR_RESET_SLEEP : `CODE_MASTER_CLEAR_RESET_RUN;
         else if (edges[SRC_WDT])
            rank_cause = in_sleep ? `CODE_WDT_WAKE : `CODE_WDT_RESET;
         else if (wake && in_sleep)
            rank_cause = `CODE_IRQ_WAKE;
         else
            rank_cause = `CODE_NONE;
      end
   endfunction

   // The two wake-up codes continue at PC+1 instead of restarting at 000h.
   function is_wake;
      input [2:0] code;
      begin
         is_wake = (code == `CODE_WDT_WAKE) || (code == `CODE_IRQ_WAKE);
      end
   endfunction

   // Status value for a cause; bits left unchanged come from the current status.
   function [7:0] status_for;
      input [2:0] code;
      input [7:0] cur;
      begin
         case (code)
            `CODE_POR: status_for = {`STATUS_POR_TOP, cur[2:0]};
            `CODE_BOR: status_for = {`STATUS_POR_TOP, cur[2:0]};
            `CODE_MASTER_CLEAR_RESET_RUN: status_for = {3'h0, cur[4:0]};
            `CODE_MASTER_CLEAR_RESET_SLEEP: status_for = {`STATUS_MASTER_CLEAR_RESET_SLEEP_TOP, cur[2:0]};
            `CODE_WDT_RESET: status_for = {4'h0, cur[3:0]};
            `CODE_WDT_WAKE: status_for = {cur[7:5], 2'b00, cur[2:0]};
            `CODE_IRQ_WAKE: status_for = {cur[7:5], 2'b10, cur[2:0]};
            default: status_for = cur;
         endcase
      end
   endfunction

   // First stage of the two-flop synchroniser for the asynchronous source pins.
   always @(posedge clk) begin
      if (sys_rst)
         sync_a <= 4'h0;
      else
         sync_a <= {watchdog_timer, master_clear_reset, bor_req, por_req};
   end

   // Second stage, and the delayed copy that the edge detector compares against.
   always @(posedge clk) begin
      if (sys_rst) begin
         sync_b <= 4'h0;
         prev_b <= 4'h0;
      end else begin
         sync_b <= sync_a;
         prev_b <= sync_b;
      end
   end

   // Cause selection. Pin edges that arrive while the sequencer is busy are lost;
   // the interrupt wake request is a level and is simply taken again later.
   always @* begin
      next_code = rank_cause(rise, sleeping, irq_wake_req);
      next_status = status_for(next_code, status_current);
      take = (state == ST_IDLE) && (next_code != `CODE_NONE);
      wake_taken = take && is_wake(next_code);
      irq_wake_taken = take && (next_code == `CODE_IRQ_WAKE);
      reset_taken = take && !is_wake(next_code);
   end

   // Register read decode; every address without a register reads as zero.
   always @* begin
      case (reg_addr)
         `ADDR_RESET_CAUSE: next_read = reset_cause_flags & `CAUSE_BITS_MASK;
         `ADDR_STATUS_COPY: next_read = status_value;
         `ADDR_CAUSE_CODE: next_read = {5'h00, cause_code};
         default: next_read = 8'h00;
      endcase
   end

   // Sequencer next state.
   always @* begin
      case (state)
         ST_IDLE: begin
            if (take)
               next_state = ST_HOLD;
            else
               next_state = ST_IDLE;
         end
         ST_HOLD: next_state = ST_WAIT;
         ST_WAIT: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // One-cycle strobes towards the core; they drop again on the next clock.
   always @(posedge clk) begin
      if (sys_rst) begin
         cause_valid <= 1'b0;
         pc_load <= 1'b0;
         status_load <= 1'b0;
         irq_load <= 1'b0;
      end else begin
         cause_valid <= take;
         pc_load <= take;
         status_load <= take;
         irq_load <= reset_taken || irq_wake_taken;
      end
   end

   // The encoded cause stays until the next one is taken.
   always @(posedge clk) begin
      if (sys_rst)
         cause_code <= `CODE_NONE;
      else if (take)
         cause_code <= next_code;
   end

   // Program counter to load: restart for resets, next instruction for wake-ups.
   always @(posedge clk) begin
      if (sys_rst)
         pc_value <= `PC_RESET_VALUE;
      else if (wake_taken)
         pc_value <= pc_current + 1'b1;
      else if (reset_taken)
         pc_value <= `PC_RESET_VALUE;
   end

   always @(posedge clk) begin
      if (sys_rst)
         status_value <= 8'h00;
      else if (take)
         status_value <= next_status;
   end

   // Interrupt flag registers: an interrupt wake-up adds its causing flags, a reset only
   // drops the global enable so nothing is serviced before software allows it.
   always @(posedge clk) begin
      if (sys_rst) begin
         irq_control_value <= 8'h00;
         peripheral_irq_value <= 8'h00;
      end else if (irq_wake_taken) begin
         irq_control_value <= irq_control_reg | irq_control_wake;
         peripheral_irq_value <= peripheral_irq_flags | peripheral_wake;
      end else if (reset_taken) begin
         irq_control_value <= {1'b0, irq_control_reg[6:0]};
         peripheral_irq_value <= peripheral_irq_flags;
      end
   end

   // The vector request stands while the core sleeps, so the core can run the
   // PC+1 instruction first and branch afterwards.
   always @(posedge clk) begin
      if (sys_rst)
         vector_pending <= 1'b0;
      else if (irq_wake_taken)
         vector_pending <= irq_control_reg[7];
      else if (reset_taken)
         vector_pending <= 1'b0;
      else if (state == ST_WAIT && !sleeping)
         vector_pending <= 1'b0;
   end

   always @(posedge clk) begin
      if (sys_rst)
         vector_value <= `PC_IRQ_VECTOR;
      else
         vector_value <= `PC_IRQ_VECTOR;
   end

   // Reset-cause flags. A power-on or brown-out cause outranks a software write in the same
   // cycle; power-on clears bit 1 and leaves bit 0 as it was.
   always @(posedge clk) begin
      if (sys_rst)
         reset_cause_flags <= 8'h00;
      else if (take && next_code == `CODE_POR)
         reset_cause_flags <= {6'h00, 1'b0, reset_cause_flags[0]};
      else if (take && next_code == `CODE_BOR)
         reset_cause_flags <= {6'h00, `CAUSE_BOR_VALUE};
      else if (reg_wr && reg_addr == `ADDR_RESET_CAUSE)
         reset_cause_flags <= reg_wdata & `CAUSE_BITS_MASK;
   end

   // Read data stands only in the cycle after the read strobe.
   always @(posedge clk) begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= next_read;
      else
         reg_rdata <= 8'h00;
   end

endmodule // reset_state_initializer

// File: reset_state_initializer_sva.sv
// Concurrent checks on the reset state initializer ports.
`timescale 1ns/10ps
`include "reset_init_map.vh"
module reset_state_initializer_sva #(parameter PC_WIDTH = 13) (
   input wire clk, sys_rst, reg_rd, cause_valid, vector_pending, // Clock, reset and flags.
   input wire [2:0] cause_code,                                // Encoded cause.
   input wire [PC_WIDTH-1:0] pc_current, pc_value,             // Program counters.
   input wire [7:0] status_value, irq_control_value, irq_control_reg, reset_cause_flags, reg_rdata // Data.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire rst_ev = cause_valid && cause_code >= `CODE_POR && cause_code <= `CODE_WDT_RESET;
   wire wake_ev = cause_valid && cause_code >= `CODE_WDT_WAKE;
   a_reset_pc_zero: assert property (rst_ev |-> pc_value == `PC_RESET_VALUE) else $error("pc not zero");
   a_gie_reset_clear: assert property (rst_ev |-> !irq_control_value[7]) else $error("gie kept");
   a_por_status_top: assert property (
      cause_valid && cause_code == `CODE_POR |-> status_value[7:3] == 5'h03) else $error("por status");
   a_master_clear_reset_sleep_top: assert property (
      cause_valid && cause_code == `CODE_MASTER_CLEAR_RESET_SLEEP |-> status_value[7:3] == 5'h02) else $error("master_clear_reset sleep status");
   a_wdt_reset_top: assert property (
      cause_valid && cause_code == `CODE_WDT_RESET |-> status_value[7:4] == 4'h0) else $error("wdt status");
   a_wake_pc_next: assert property (
      wake_ev |-> pc_value == pc_current + 1'b1 && !status_value[3]) else $error("wake pc");
   a_bor_flags_set: assert property (
      cause_valid && cause_code == `CODE_BOR |-> ##[0:1] reset_cause_flags[1:0] == 2'h2) else $error("bor flags");
   a_vector_after_wake: assert property (
      cause_valid && cause_code == `CODE_IRQ_WAKE && irq_control_reg[7] |-> ##[0:1] vector_pending)
      else $error("no vector");
   a_flags_upper_zero: assert property (reset_cause_flags[7:2] == 6'h00) else $error("flags upper");
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata idle");
   a_cause_one_cycle: assert property (cause_valid |=> !cause_valid) else $error("valid long");
   c_por: cover property (cause_valid && cause_code == `CODE_POR);
   c_irq_wake: cover property (cause_valid && cause_code == `CODE_IRQ_WAKE);
   c_read: cover property (reg_rd);
   c_wdt_wake: cover property (cause_valid && cause_code == `CODE_WDT_WAKE);
endmodule // reset_state_initializer_sva

// File: tb_reset_state_initializer.sv
// Directed testbench for the reset state initializer.
`timescale 1ns/10ps
`include "reset_init_map.vh"
module tb_reset_state_initializer;
   reg clk = 0, sys_rst = 1, sleeping = 0, reg_wr = 0, reg_rd = 0;
   reg [4:0] pins = 0;
   reg [12:0] pc_current = 13'h0123;
   reg [7:0] status_current = 8'hce, irq_control_reg = 8'h80, peripheral_irq_flags = 8'h01;
   reg [7:0] irq_control_wake = 8'h02, peripheral_wake = 8'h04, reg_addr = 0, reg_wdata = 0;
   wire por_req = pins[0], bor_req = pins[1], master_clear_reset = pins[2];
   wire watchdog_timer = pins[3], irq_wake_req = pins[4];
   wire [7:0] reg_rdata, status_value, irq_control_value, peripheral_irq_value, reset_cause_flags;
   wire [2:0] cause_code;
   wire [12:0] pc_value, vector_value;
   wire cause_valid, pc_load, status_load, irq_load, vector_pending;
   integer mismatches = 0, n_compared = 0, i;
   reset_state_initializer u_reset_state_initializer (.clk(clk), .sys_rst(sys_rst), .por_req(por_req),
      .bor_req(bor_req), .master_clear_reset(master_clear_reset), .watchdog_timer(watchdog_timer),
      .irq_wake_req(irq_wake_req), .sleeping(sleeping), .pc_current(pc_current), .status_current(status_current),
      .irq_control_reg(irq_control_reg), .peripheral_irq_flags(peripheral_irq_flags),
      .irq_control_wake(irq_control_wake), .peripheral_wake(peripheral_wake), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cause_code(cause_code),
      .cause_valid(cause_valid), .pc_load(pc_load), .pc_value(pc_value), .status_load(status_load),
      .status_value(status_value), .irq_load(irq_load), .irq_control_value(irq_control_value),
      .peripheral_irq_value(peripheral_irq_value), .vector_pending(vector_pending), .vector_value(vector_value),
      .reset_cause_flags(reset_cause_flags));
   initial forever #5 clk = ~clk;
   task close_out;
      if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task cmp(input [12:0] got, input [12:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task ev(input integer p, input [2:0] code, input [12:0] pc, input [7:0] st);
      @(posedge clk) pins[p] <= 1;
      for (i = 0; i < 10 && cause_valid !== 1'b1; i = i + 1) @(posedge clk) #1;
      if (i == 10) begin
         cmp(0, 1);
         close_out;
      end
      cmp(cause_code, code);
      cmp(pc_value, pc);
      cmp(status_value, st);
      cmp({pc_load, status_load, irq_load}, {2'b11, code != `CODE_WDT_WAKE});
      @(posedge clk) pins[p] <= 0;
      #1 cmp(cause_valid, 0);
      repeat (5) @(posedge clk);
   endtask
   task rd(input [7:0] a, input [7:0] exp);
      @(posedge clk) begin
         reg_rd <= 1;
         reg_addr <= a;
      end
      @(posedge clk) reg_rd <= 0;
      #1 cmp(reg_rdata, exp);
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk) begin
         reg_wr <= 1;
         reg_addr <= a;
         reg_wdata <= d;
      end
      @(posedge clk) reg_wr <= 0;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 0;
      ev(0, `CODE_POR, 0, 8'h1e);
      rd(`ADDR_RESET_CAUSE, 8'h00);
      wr(`ADDR_RESET_CAUSE, 8'hff);
      rd(`ADDR_RESET_CAUSE, 8'h03);
      ev(2, `CODE_MASTER_CLEAR_RESET_RUN, 0, 8'h0e);
      rd(`ADDR_RESET_CAUSE, 8'h03);
      ev(1, `CODE_BOR, 0, 8'h1e);
      rd(`ADDR_RESET_CAUSE, 8'h02);
      ev(3, `CODE_WDT_RESET, 0, 8'h0e);
      sleeping <= 1;
      ev(2, `CODE_MASTER_CLEAR_RESET_SLEEP, 0, 8'h16);
      ev(3, `CODE_WDT_WAKE, 13'h0124, 8'hc6);
      ev(4, `CODE_IRQ_WAKE, 13'h0124, 8'hd6);
      cmp(irq_control_value, 8'h82);
      cmp(peripheral_irq_value, 8'h05);
      cmp(vector_pending, 1);
      cmp(vector_value, `PC_IRQ_VECTOR);
      rd(`ADDR_CAUSE_CODE, `CODE_IRQ_WAKE);
      rd(`ADDR_STATUS_COPY, 8'hd6);
      rd(8'h40, 8'h00);
      close_out;
   end
endmodule // tb_reset_state_initializer
bind reset_state_initializer reset_state_initializer_sva #(.PC_WIDTH(PC_WIDTH)) u_reset_state_initializer_sva (
   .clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .cause_valid(cause_valid), .vector_pending(vector_pending),
   .cause_code(cause_code), .pc_current(pc_current), .pc_value(pc_value), .status_value(status_value),
   .irq_control_value(irq_control_value), .irq_control_reg(irq_control_reg),
   .reset_cause_flags(reset_cause_flags), .reg_rdata(reg_rdata));
